// *** hdl/seal_pkg.sv ***
// Constants, types and register map of the serial memory configuration loader
// How it works
// - The memory link is exactly two pins, a serial clock driven out by the device and one two-way data line.
// - The loader reaches all 512 bytes of the memory, using the page bit of the device select for the upper half.
// - Right after reset is released the loader fetches the configuration image before anything else happens.
// - The memory is seen as 16-bit words and every access carries a 7-bit word address.
// - The chip-select address bits of the device select are always sent as zero and the board straps them so.
// - A hardware sequencer does software-started word reads and writes from start, address and command fields.
// - After reset word zero is read and the automatic load starts only if it equals the expected signature.
// - The automatic load reads consecutive words upward and stores each into its configuration register.
// - The load-status flag at bit 3 of offset DCh is one while loading and zero when done, and the host polls it.
// - Words 02h and 04h become the vendor and device identifiers and the low byte of word 0Eh the revision.
// - Word 06h is applied to the channel count, link capability, mode and interrupt pin settings.
// - Word 10h carries the training, clock and scrambling settings of port 0, the next words those of ports 1 and 2.
// - Words 18h and 1Ah load physical control groups 0 and 1, and only bits 6 to 0 of group 2 come from word 1Ch.
package seal_pkg;
  // Register map (control byte address; configuration page number in address bits 11 to 6)
  localparam logic [11:0] REG_CONTROL = 12'h0dc;
  localparam logic [5:0] REG_CFG_PAGE = 6'h04;
  // Control register fields
  localparam int CTL_START_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_SIGOK_BIT = 2;
  localparam int CTL_BUSY_BIT = 3;
  localparam int CTL_NACK_BIT = 4;
  localparam int CTL_ADDR_LSB = 8;
  localparam int CTL_PAGE_BIT = 15;
  localparam int CTL_DATA_LSB = 16;
  // Image layout
  localparam logic [15:0] SIGNATURE = 16'h1516;
  localparam logic [6:0] WORD_FIRST = 7'h01;
  localparam logic [6:0] WORD_LAST = 7'h0e;
  localparam logic [6:0] WORD_REV = 7'h07;
  localparam logic [6:0] WORD_PHY2 = 7'h0e;
  localparam logic [15:0] MASK_REV = 16'h00ff;
  localparam logic [15:0] MASK_PHY2 = 16'h007f;
  localparam logic [15:0] CFG_DEFAULT = 16'h0000;
  // Device select
  localparam logic [3:0] DEVSEL_TYPE = 4'ha;
  localparam logic [1:0] DEVSEL_STRAP = 2'h0;
  // Timing
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int TWI_QUARTER_NS = 2500;
  localparam int TWI_QUARTER_CYC = (TWI_QUARTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WRITE_CYCLE_NS = 5000000;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Byte engine operations
  typedef logic [1:0] seal_op_t;
  localparam seal_op_t OP_START = 2'h0;
  localparam seal_op_t OP_STOP = 2'h1;
  localparam seal_op_t OP_WRITE = 2'h2;
  localparam seal_op_t OP_READ = 2'h3;
  // Transfer purposes
  typedef logic [1:0] seal_purpose_t;
  localparam seal_purpose_t P_SIG = 2'h0;
  localparam seal_purpose_t P_LOAD = 2'h1;
  localparam seal_purpose_t P_SEQ = 2'h2;
  typedef enum logic [3:0] {E_IDLE = 4'b0001, E_START = 4'b0010, E_STOP = 4'b0100, E_BITS = 4'b1000} seal_eng_e;
  typedef enum logic [2:0] {ST_XFER = 3'b001, ST_WRWAIT = 3'b010, ST_IDLE = 3'b100} seal_ctl_e;
endpackage

// *** hdl/seal_mem.sv ***
// Small word memory that holds the loaded configuration image
`timescale 1ns/1ps
module seal_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  // Clock
  input wire logic clock,
  input wire logic clock_en,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (we) begin
        store[waddr] <= wdata;
      end
      rdata <= store[raddr];
    end
  end
endmodule // seal_mem

// *** hdl/seal_twi.sv ***
// Two-wire byte engine: start, stop, byte write and byte read with acknowledge
`timescale 1ns/1ps
module seal_twi
  import seal_pkg::*;
#(
  parameter int QUARTER_CYCLES = seal_pkg::TWI_QUARTER_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // Command
  input wire logic cmd_valid,
  input wire seal_pkg::seal_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rx_data,
  output logic rx_ack,
  // Memory link
  output logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  typedef struct packed {
    seal_eng_e state;
    logic [15:0] div;
    logic [1:0] quarter;
    logic [3:0] bitn;
    logic [8:0] shift;
    logic samp;
    logic sda_meta;
    logic sda_sync;
    logic scl;
    logic sda_low;
    logic done;
    logic [7:0] rx_data;
    logic rx_ack;
  } seal_twi_s;

  seal_twi_s r, n;
  logic tick;

  always_comb begin
    n = r;
    tick = 1'b0;
    n.done = 1'b0;
    n.sda_meta = sda_i;
    n.sda_sync = r.sda_meta;
    if (r.state == E_IDLE) begin
      if (cmd_valid) begin
        n.div = 16'h0000;
        n.quarter = 2'h0;
        n.bitn = 4'h0;
        case (cmd_op)
          OP_START: n.state = E_START;
          OP_STOP: n.state = E_STOP;
          OP_WRITE: begin
            n.state = E_BITS;
            n.shift = {cmd_data, 1'b1};
          end
          default: begin
            n.state = E_BITS;
            n.shift = {8'hff, cmd_nack};
          end
        endcase
      end
    end else begin
      if (r.div == 16'(QUARTER_CYCLES - 1)) begin
        n.div = 16'h0000;
        tick = 1'b1;
      end else begin
        n.div = r.div + 16'h0001;
      end
      if (tick) begin
        n.quarter = r.quarter + 2'h1;
        // Sample at the end of the high clock phase
        if (r.state == E_BITS && r.quarter == 2'h2) begin
          n.samp = r.sda_sync;
        end
        if (r.quarter == 2'h3) begin
          if (r.state == E_BITS) begin
            n.shift = {r.shift[7:0], r.samp};
            if (r.bitn == 4'h8) begin
              n.state = E_IDLE;
              n.done = 1'b1;
              n.rx_data = r.shift[7:0];
              n.rx_ack = ~r.samp;
            end else begin
              n.bitn = r.bitn + 4'h1;
            end
          end else begin
            n.state = E_IDLE;
            n.done = 1'b1;
          end
        end
      end
    end
    // Pin levels per quarter; idle holds the last levels
    case (n.state)
      E_START: begin
        n.scl = (n.quarter == 2'h1) || (n.quarter == 2'h2);
        n.sda_low = n.quarter[1];
      end
      E_STOP: begin
        n.scl = (n.quarter != 2'h0);
        n.sda_low = (n.quarter == 2'h0) || (n.quarter == 2'h1);
      end
      E_BITS: begin
        n.scl = (n.quarter == 2'h1) || (n.quarter == 2'h2);
        n.sda_low = ~n.shift[8];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '{state: E_IDLE, scl: 1'b1, default: '0};
    end else if (clock_en) begin
      r <= n;
    end
  end

  assign cmd_ready = (r.state == E_IDLE);
  assign done = r.done;
  assign rx_data = r.rx_data;
  assign rx_ack = r.rx_ack;
  assign scl = r.scl;
  assign sda_o = 1'b0;
  assign sda_oe = r.sda_low;
endmodule // seal_twi

// *** hdl/seal_top.sv ***
// Serial memory configuration loader with word sequencer and Wishbone register slave
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module seal_top
  import seal_pkg::*;
#(
  parameter int QUARTER_CYCLES = seal_pkg::TWI_QUARTER_CYC,
  parameter int WRITE_WAIT_CYCLES = seal_pkg::WRITE_CYCLE_CYC
) (
  // Clock, reset and enable
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_EN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Memory link
  output logic MEMORY_SERIAL_CLOCK,
  input wire logic MEMORY_SERIAL_DATA_I,
  output logic MEMORY_SERIAL_DATA_O,
  output logic MEMORY_SERIAL_DATA_OE,
  // Status
  output logic LOAD_BUSY
);
  ////////////////////////////////////////////////////////////////////////////
  // Step kinds of one word transfer

  localparam logic [3:0] K_START = 4'h0;
  localparam logic [3:0] K_DEVW = 4'h1;
  localparam logic [3:0] K_ADDR = 4'h2;
  localparam logic [3:0] K_DEVR = 4'h3;
  localparam logic [3:0] K_RDLO = 4'h4;
  localparam logic [3:0] K_RDHI = 4'h5;
  localparam logic [3:0] K_WRLO = 4'h6;
  localparam logic [3:0] K_WRHI = 4'h7;
  localparam logic [3:0] K_STOP = 4'h8;
  localparam logic [3:0] K_END = 4'h9;

  // Read: start, select W, address, restart, select R, two bytes, stop
  function automatic logic [3:0] step_kind(input logic wr, input logic [3:0] step);
    logic [3:0] k;
    k = K_END;
    if (!wr) begin
      case (step)
        4'h0: k = K_START;
        4'h1: k = K_DEVW;
        4'h2: k = K_ADDR;
        4'h3: k = K_START;
        4'h4: k = K_DEVR;
        4'h5: k = K_RDLO;
        4'h6: k = K_RDHI;
        4'h7: k = K_STOP;
        default: k = K_END;
      endcase
    end else begin
      // Write: start, select W, address, two bytes, stop
      case (step)
        4'h0: k = K_START;
        4'h1: k = K_DEVW;
        4'h2: k = K_ADDR;
        4'h3: k = K_WRLO;
        4'h4: k = K_WRHI;
        4'h5: k = K_STOP;
        default: k = K_END;
      endcase
    end
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Transfer controller
    seal_ctl_e state;
    seal_purpose_t purpose;
    logic [3:0] step;
    logic waiting;
    logic [6:0] word;
    logic page;
    logic wr_cmd;
    logic [15:0] data;
    logic busy;
    logic sig_ok;
    logic nack;
    logic [15:0] loaded;
    logic [19:0] wait_cnt;
    // Engine command register
    logic cmd_valid;
    seal_op_t cmd_op;
    logic [7:0] cmd_data;
    logic cmd_nack;
    // Image store write port
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [15:0] mem_wdata;
    // Bus answer
    logic wb_pend;
    logic ack;
    logic [31:0] dat_o;
  } seal_top_s;

  seal_top_s r, n;
  // Engine and store results
  logic eng_ready;
  logic eng_done;
  logic [7:0] eng_rx_data;
  logic eng_rx_ack;
  logic [15:0] mem_rdata;
  // Decode helpers
  logic [3:0] kind;
  logic wb_take;
  logic wb_ctl_hit;
  logic wb_cfg_hit;
  logic [31:0] rd_value;
  logic [15:0] store_word;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.cmd_valid = 1'b0;
    n.mem_we = 1'b0;
    kind = step_kind(r.wr_cmd, r.step);
    store_word = r.data;
    // A request is taken only when no answer is in flight
    wb_take = WB_CYC_I && WB_STB_I && !r.wb_pend && !r.ack;
    wb_ctl_hit = (WB_ADR_I[11:2] == REG_CONTROL[11:2]);
    wb_cfg_hit = (WB_ADR_I[11:6] == REG_CFG_PAGE);
    rd_value = 32'h0000_0000;

    // Engine results
    if (r.waiting && eng_done) begin
      n.waiting = 1'b0;
      n.step = r.step + 4'h1;
      case (kind)
        // A missing acknowledge is recorded, the transfer goes on
        K_DEVW, K_ADDR, K_DEVR, K_WRLO, K_WRHI: begin
          if (!eng_rx_ack) begin
            n.nack = 1'b1;
          end
        end
        K_RDLO: n.data[7:0] = eng_rx_data;
        K_RDHI: n.data[15:8] = eng_rx_data;
        default: begin
        end
      endcase
    end

    case (r.state)
      ST_XFER: begin
        // Issue the next step only once the engine is idle again
        if (!r.waiting && eng_ready && !r.cmd_valid) begin
          if (kind == K_END) begin
            n.step = 4'h0;
            case (r.purpose)
              // Signature decides between load and skip
              P_SIG: begin
                if (r.data == SIGNATURE) begin
                  n.sig_ok = 1'b1;
                  n.purpose = P_LOAD;
                  n.word = WORD_FIRST;
                end else begin
                  n.busy = 1'b0;
                  n.state = ST_IDLE;
                end
              end
              P_LOAD: begin
                // Revision and third control group keep only their defined bits
                if (r.word == WORD_REV) begin
                  store_word = r.data & MASK_REV;
                end else if (r.word == WORD_PHY2) begin
                  store_word = r.data & MASK_PHY2;
                end
                // Word index equals byte offset over two: 02h, 04h, 06h, 10h, 18h land in slots 1, 2, 3, 8, 12
                n.mem_we = 1'b1;
                n.mem_waddr = r.word[3:0];
                n.mem_wdata = store_word;
                n.loaded[r.word[3:0]] = 1'b1;
                if (r.word == WORD_LAST) begin
                  n.busy = 1'b0;
                  n.state = ST_IDLE;
                end else begin
                  n.word = r.word + 7'h01;
                end
              end
              default: begin
                // Sequencer: a write waits out the memory's internal write time
                if (r.wr_cmd) begin
                  n.state = ST_WRWAIT;
                  n.wait_cnt = 20'h00000;
                end else begin
                  n.busy = 1'b0;
                  n.state = ST_IDLE;
                end
              end
            endcase
          end else begin
            n.cmd_valid = 1'b1;
            n.waiting = 1'b1;
            n.cmd_nack = (kind == K_RDHI);
            n.cmd_data = 8'h00;
            // Operation and byte of the step
            case (kind)
              K_START: n.cmd_op = OP_START;
              K_STOP: n.cmd_op = OP_STOP;
              K_RDLO, K_RDHI: n.cmd_op = OP_READ;
              default: n.cmd_op = OP_WRITE;
            endcase
            case (kind)
              K_DEVW: n.cmd_data = {DEVSEL_TYPE, DEVSEL_STRAP, r.page, 1'b0};
              K_DEVR: n.cmd_data = {DEVSEL_TYPE, DEVSEL_STRAP, r.page, 1'b1};
              K_ADDR: n.cmd_data = {r.word, 1'b0};
              K_WRLO: n.cmd_data = r.data[7:0];
              K_WRHI: n.cmd_data = r.data[15:8];
              default: n.cmd_data = 8'h00;
            endcase
          end
        end
      end
      ST_WRWAIT: begin
        // Memory internal write time before the next access
        if (r.wait_cnt == 20'(WRITE_WAIT_CYCLES - 1)) begin
          n.busy = 1'b0;
          n.state = ST_IDLE;
        end else begin
          n.wait_cnt = r.wait_cnt + 20'h00001;
        end
      end
      default: begin
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: take, then answer one cycle later

    if (r.ack) begin
      n.ack = 1'b0;
    end
    if (wb_take) begin
      n.wb_pend = 1'b1;
    end
    if (r.wb_pend) begin
      n.wb_pend = 1'b0;
      n.ack = 1'b1;
      // Read data; unmapped addresses read zero
      if (wb_ctl_hit) begin
        rd_value[CTL_WRITE_BIT] = r.wr_cmd;
        rd_value[CTL_SIGOK_BIT] = r.sig_ok;
        rd_value[CTL_BUSY_BIT] = r.busy;
        rd_value[CTL_NACK_BIT] = r.nack;
        rd_value[CTL_ADDR_LSB +: 7] = r.word;
        rd_value[CTL_PAGE_BIT] = r.page;
        rd_value[CTL_DATA_LSB +: 16] = r.data;
      end else if (wb_cfg_hit) begin
        rd_value[15:0] = r.loaded[WB_ADR_I[5:2]] ? mem_rdata : CFG_DEFAULT;
      end
      n.dat_o = WB_WE_I ? 32'h0000_0000 : rd_value;
      // Fields are frozen while an access runs; a start then is ignored
      if (WB_WE_I && wb_ctl_hit && !r.busy) begin
        if (WB_SEL_I[0]) begin
          n.wr_cmd = WB_DAT_I[CTL_WRITE_BIT];
        end
        if (WB_SEL_I[1]) begin
          n.word = WB_DAT_I[CTL_ADDR_LSB +: 7];
          n.page = WB_DAT_I[CTL_PAGE_BIT];
        end
        if (WB_SEL_I[2]) begin
          n.data[7:0] = WB_DAT_I[CTL_DATA_LSB +: 8];
        end
        if (WB_SEL_I[3]) begin
          n.data[15:8] = WB_DAT_I[CTL_DATA_LSB + 8 +: 8];
        end
        // Start needs the lowest byte lane
        if (WB_SEL_I[0] && WB_DAT_I[CTL_START_BIT]) begin
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.purpose = P_SEQ;
          n.step = 4'h0;
          n.state = ST_XFER;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset starts the signature read at word zero

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r <= '{state: ST_XFER, purpose: P_SIG, busy: 1'b1, cmd_op: OP_START, default: '0};
    end else if (CLOCK_EN) begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine and image store

  seal_twi #(
    .QUARTER_CYCLES(QUARTER_CYCLES)
  ) seal_twi_inst (
    .clock(CLOCK),
    .reset(RESET),
    .clock_en(CLOCK_EN),
    .cmd_valid(r.cmd_valid),
    .cmd_op(r.cmd_op),
    .cmd_data(r.cmd_data),
    .cmd_nack(r.cmd_nack),
    .cmd_ready(eng_ready),
    .done(eng_done),
    .rx_data(eng_rx_data),
    .rx_ack(eng_rx_ack),
    .scl(MEMORY_SERIAL_CLOCK),
    .sda_i(MEMORY_SERIAL_DATA_I),
    .sda_o(MEMORY_SERIAL_DATA_O),
    .sda_oe(MEMORY_SERIAL_DATA_OE)
  );

  // Image words are indexed by the low bits of the word address
  seal_mem #(
    .AW(4),
    .DW(16)
  ) seal_mem_inst (
    .clock(CLOCK),
    .clock_en(CLOCK_EN),
    .we(r.mem_we),
    .waddr(r.mem_waddr),
    .wdata(r.mem_wdata),
    .raddr(WB_ADR_I[5:2]),
    .rdata(mem_rdata)
  );

  // Outputs straight from registers
  assign WB_DAT_O = r.dat_o;
  assign WB_ACK_O = r.ack;
  assign LOAD_BUSY = r.busy;
endmodule // seal_top

// *** dv/seal_checker.sv ***
// Port-level checks of the serial memory configuration loader
`timescale 1ns/1ps
module seal_checker #(
  parameter int QUARTER_CYCLES = 2,
  parameter int WRITE_WAIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_EN,
  // Wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Memory link
  input wire logic MEMORY_SERIAL_CLOCK,
  input wire logic MEMORY_SERIAL_DATA_I,
  input wire logic MEMORY_SERIAL_DATA_O,
  input wire logic MEMORY_SERIAL_DATA_OE,
  // Status
  input wire logic LOAD_BUSY
);
  import seal_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////
  property p_ack_latency;
    $rose(WB_STB_I) && WB_CYC_I |-> !WB_ACK_O ##1 !WB_ACK_O ##1 WB_ACK_O;
  endproperty
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  property p_ack_in_cycle;
    WB_ACK_O |-> WB_CYC_I && WB_STB_I;
  endproperty
  property p_unmapped_zero;
    $rose(WB_STB_I) && !WB_WE_I && WB_ADR_I == 12'h000 |-> ##2 WB_DAT_O == 32'h0;
  endproperty
  property p_data_low;
    MEMORY_SERIAL_DATA_O == 1'b0;
  endproperty
  property p_load_at_reset;
    $fell(RESET) |-> LOAD_BUSY ##[1:20] (MEMORY_SERIAL_DATA_OE && MEMORY_SERIAL_CLOCK);
  endproperty
  // High phase spans two quarters of two clocks each
  property p_scl_high_width;
    $rose(MEMORY_SERIAL_CLOCK) |-> MEMORY_SERIAL_CLOCK[*4];
  endproperty
  property p_sda_setup;
    $rose(MEMORY_SERIAL_CLOCK) |-> $stable(MEMORY_SERIAL_DATA_OE);
  endproperty
  property p_idle_link;
    !LOAD_BUSY |-> MEMORY_SERIAL_CLOCK && !MEMORY_SERIAL_DATA_OE;
  endproperty
  property p_seq_busy;
    $rose(WB_STB_I) && WB_WE_I && WB_ADR_I == REG_CONTROL && WB_SEL_I[0] && WB_DAT_I[CTL_START_BIT] && !LOAD_BUSY
      |-> ##[1:3] LOAD_BUSY;
  endproperty
  ////////////////////////////////////////////////////////////
  a_ack_latency: assert property (p_ack_latency)
    else $error("bus answer not two edges after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus answer longer than one cycle");
  a_ack_in_cycle: assert property (p_ack_in_cycle)
    else $error("bus answer outside a cycle");
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  a_data_low: assert property (p_data_low)
    else $error("data line driven high");
  a_load_at_reset: assert property (p_load_at_reset)
    else $error("no load started after reset");
  a_scl_high_width: assert property (p_scl_high_width)
    else $error("serial clock high phase too short");
  a_sda_setup: assert property (p_sda_setup)
    else $error("data changed with serial clock rise");
  a_idle_link: assert property (p_idle_link)
    else $error("link active while not busy");
  a_seq_busy: assert property (p_seq_busy)
    else $error("sequencer start did not set busy");
  c_load_done: cover property ($fell(LOAD_BUSY));
  c_seq_start: cover property ($rose(LOAD_BUSY));
  c_unmapped: cover property ($rose(WB_STB_I) && WB_ADR_I == 12'h000);
endmodule // seal_checker

// *** dv/seal_mem_model.sv ***
// Behavioural two-wire serial memory of 512 bytes
`timescale 1ns/1ps
module seal_mem_model (
  // Link
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] mem [0:511];
  logic [7:0] sh;
  logic [8:0] ptr;
  logic page;
  logic mack;
  int st;
  int bitn;
  initial begin
    sda_oe = 1'b0;
    st = 0;
    bitn = 0;
  end
  // Start and stop conditions
  always @(negedge sda) if (scl === 1'b1) begin
    st = 1;
    bitn = 0;
  end
  always @(posedge sda) if (scl === 1'b1) st = 0;
  always @(posedge scl) if (st != 0) begin
    if (bitn < 8 && st != 4) sh = {sh[6:0], sda};
    if (bitn == 8) mack = sda;
    bitn++;
  end
  // Data changes only while the clock is low
  always @(negedge scl) if (st != 0) begin
    sda_oe = 1'b0;
    if (bitn == 8 && st != 4) begin
      sda_oe = 1'b1;
      if (st == 1) begin
        page = sh[1];
        st = sh[0] ? 4 : 2;
        if (sh[7:4] != 4'ha || sh[3:2] != 2'b00) begin
          sda_oe = 1'b0;
          st = 0;
        end
      end else if (st == 2) begin
        ptr = {page, sh};
        st = 3;
      end else begin
        mem[ptr] = sh;
        ptr++;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      if (st == 4 && mack) st = 0;
      else if (st == 4) begin
        sh = mem[ptr];
        ptr++;
      end
    end
    if (st == 4 && bitn < 8) sda_oe = !sh[7-bitn];
  end
endmodule // seal_mem_model

// *** dv/seal_top_tb.sv ***
// Self-checking bench of the serial memory configuration loader
`timescale 1ns/1ps
`define chk(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module seal_top_tb;
  import seal_pkg::*;
  logic clk, rst, cyc, stb, we, ack, scl, sda, sda_o, dut_oe, mem_oe, busy, ce, scl_held;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o, got;
  logic [15:0] e, w;
  int error_cnt, compares, i;
  assign sda = !(dut_oe || mem_oe);
  seal_top #(.QUARTER_CYCLES(2), .WRITE_WAIT_CYCLES(20)) seal_top_inst (
    .CLOCK(clk), .RESET(rst), .CLOCK_EN(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .MEMORY_SERIAL_CLOCK(scl), .MEMORY_SERIAL_DATA_I(sda), .MEMORY_SERIAL_DATA_O(sda_o),
    .MEMORY_SERIAL_DATA_OE(dut_oe), .LOAD_BUSY(busy));
  seal_mem_model seal_mem_model_inst (.scl(scl), .sda(sda), .sda_oe(mem_oe));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] img(input int k);
    img = {8'h5a ^ 8'(k), 8'hb0 + 8'(k)};
  endfunction
  task automatic wb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    got = dat_o;
    `chk(n, 3)
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      wb(1'b0, REG_CONTROL, 32'h0);
      k++;
    end while (got[CTL_BUSY_BIT] !== 1'b0 && k < 3000);
    `chk(got[CTL_BUSY_BIT], 1'b0)
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `chk(busy, 1'b1)
  endtask
  task automatic results();
    $display("Mismatches: %0d, comparisons: %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 12'h000;
    sel = 4'hf;
    ce = 1'b1;
    wdat = 32'h0;
    error_cnt = 0;
    compares = 0;
    for (i = 0; i < 16; i++) begin
      w = (i == 0) ? 16'h1516 : img(i);
      seal_mem_model_inst.mem[2*i] = w[7:0];
      seal_mem_model_inst.mem[2*i+1] = w[15:8];
    end
    do_reset();
    wb(1'b0, REG_CONTROL, 32'h0);
    `chk(got[CTL_BUSY_BIT], 1'b1)
    // Clock enable low freezes the load and the link
    ce <= 1'b0;
    @(posedge clk);
    scl_held = scl;
    repeat (30) @(posedge clk);
    `chk(scl, scl_held)
    `chk(sda_o, 1'b0)
    ce <= 1'b1;
    wait_idle();
    `chk(got[CTL_SIGOK_BIT], 1'b1)
    `chk(got[14:8], 7'h0e)
    for (i = 0; i < 16; i++) begin
      e = (i >= 1 && i <= 14) ? img(i) : 16'h0000;
      if (i == 7) e = e & 16'h00ff;
      if (i == 14) e = e & 16'h007f;
      wb(1'b0, 12'(12'h100 + 4 * i), 32'h0);
      `chk(got, {16'h0000, e})
    end
    wb(1'b0, 12'h000, 32'h0);
    `chk(got, 32'h0)
    // Word write to the upper half of the memory
    wb(1'b1, REG_CONTROL, 32'hbeef_a503);
    `chk(busy, 1'b1)
    wb(1'b1, REG_CONTROL, 32'h0000_3001);
    wait_idle();
    `chk(got[14:8], 7'h25)
    `chk(seal_mem_model_inst.mem[9'h14a], 8'hef)
    `chk(seal_mem_model_inst.mem[9'h14b], 8'hbe)
    seal_mem_model_inst.mem[9'h060] = 8'h34;
    seal_mem_model_inst.mem[9'h061] = 8'h12;
    for (i = 0; i < 2; i++) begin
      wb(1'b1, REG_CONTROL, i == 0 ? 32'h0000_3001 : 32'h0000_a501);
      wait_idle();
      `chk(got[31:16], i == 0 ? 16'h1234 : 16'hbeef)
      `chk(got[CTL_NACK_BIT], 1'b0)
    end
    // Broken signature skips the load
    seal_mem_model_inst.mem[0] = 8'h17;
    do_reset();
    wait_idle();
    `chk(got[CTL_SIGOK_BIT], 1'b0)
    wb(1'b0, 12'h104, 32'h0);
    `chk(got, 32'h0)
    results();
  end
endmodule // seal_top_tb
bind seal_top seal_checker #(.QUARTER_CYCLES(QUARTER_CYCLES), .WRITE_WAIT_CYCLES(WRITE_WAIT_CYCLES)) seal_checker_inst (
  .CLOCK(CLOCK), .RESET(RESET), .CLOCK_EN(CLOCK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .MEMORY_SERIAL_CLOCK(MEMORY_SERIAL_CLOCK), .MEMORY_SERIAL_DATA_I(MEMORY_SERIAL_DATA_I),
  .MEMORY_SERIAL_DATA_O(MEMORY_SERIAL_DATA_O), .MEMORY_SERIAL_DATA_OE(MEMORY_SERIAL_DATA_OE), .LOAD_BUSY(LOAD_BUSY));
